// file: design/card_port_status_flags.sv
// card port status flags with control, mode config and apb slave
`timescale 1ns/1ps
`default_nettype none
`include "card_port_defines.svh"

module card_port_status_flags (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire card_port_pkg::pins_t pins,
    input wire card_port_pkg::engine_events_t events,
    input wire card_port_pkg::engine_levels_t levels,
    output card_port_pkg::control_t control,
    output card_port_pkg::mode_t mode,
    output logic [31:0] card_port_status
);

    // ********************
    // pin synchronisers
    // ********************
    logic [`SYNC_WIDTH-1:0] pins_sync;

    pin_sync #(
        .WIDTH(`SYNC_WIDTH)
    ) u_pin_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .async_in(pins),
        .sync_out(pins_sync)
    );

    // ********************
    // state
    // ********************
    card_port_pkg::status_state_t state;
    card_port_pkg::status_state_t next_state;

    logic setup;
    logic access;
    logic write_access;
    logic hit_status;
    logic hit_control;
    logic hit_mode;
    logic mapped;
    logic card_clock_rise;
    logic send_pulse;
    logic read_pulse;
    logic write_pulse;
    logic boot_clear;
    logic [18:0] set_mask;
    logic [18:0] clear_mask;
    logic [31:0] read_word;

    // ********************
    // bus decode
    // ********************
    always_comb begin
        setup = psel && !penable;
        access = psel && penable;
        write_access = access && pwrite && ce;
        hit_status = paddr == `ADDR_STATUS;
        hit_control = paddr == `ADDR_CONTROL;
        hit_mode = paddr == `ADDR_MODE_CONFIG;
        mapped = hit_status || hit_control || hit_mode;
    end

    // ********************
    // firmware strobes
    // ********************
    // a 1 written to a start bit relaunches the operation and clears flags
    always_comb begin
        send_pulse = write_access && hit_control &&
            pwdata[`BIT_SEND_COMMAND];
        read_pulse = write_access && hit_control &&
            pwdata[`BIT_START_READ];
        write_pulse = write_access && hit_control &&
            pwdata[`BIT_START_WRITE];
        // falling edge of the expect setting only
        boot_clear = write_access && hit_mode &&
            state.mode.expect_boot_acknowledge &&
            !pwdata[`BIT_EXPECT_BOOT_ACK];
    end

    // ********************
    // link clock edge
    // ********************
    // the card clock is slow enough to be sampled on pclk
    always_comb begin
        card_clock_rise = pins_sync[`PIN_CARD_CLOCK] &&
            !state.card_clock_prev;
    end

    // ********************
    // sticky event sets and clears
    // ********************
    always_comb begin
        set_mask = '0;
        clear_mask = '0;
        set_mask[`ST_READ_END_ERROR] = events.last_read_byte &&
            state.mode.read_end_clock_stop &&
            levels.counting_busy;
        clear_mask[`ST_READ_END_ERROR] = read_pulse;
        set_mask[`ST_BOOT_ACK] = events.boot_ack;
        clear_mask[`ST_BOOT_ACK] = boot_clear;
        set_mask[`ST_COMMAND_COMPLETE] = events.command_complete;
        clear_mask[`ST_COMMAND_COMPLETE] = send_pulse;
        set_mask[`ST_FIFO_UNDERFLOW] = events.write_underflow;
        clear_mask[`ST_FIFO_UNDERFLOW] = write_pulse;
        set_mask[`ST_FIFO_OVERFLOW] = events.read_overflow;
        clear_mask[`ST_FIFO_OVERFLOW] = read_pulse;
        set_mask[`ST_DATA_CRC_ERROR] = events.data_crc_error;
        clear_mask[`ST_DATA_CRC_ERROR] = read_pulse || write_pulse;
        set_mask[`ST_READ_TIMEOUT] = events.read_timeout;
        clear_mask[`ST_READ_TIMEOUT] = read_pulse;
        set_mask[`ST_READ_DONE] = events.read_blocks_done;
        clear_mask[`ST_READ_DONE] = read_pulse;
        set_mask[`ST_WRITE_DONE] = events.write_blocks_done;
        clear_mask[`ST_WRITE_DONE] = write_pulse;
        set_mask[`ST_RESPONSE_CRC_ERROR] = events.response_crc_error;
        clear_mask[`ST_RESPONSE_CRC_ERROR] = send_pulse;
        set_mask[`ST_RESPONSE_TIMEOUT] = events.response_timeout;
        clear_mask[`ST_RESPONSE_TIMEOUT] = send_pulse;
        set_mask[`ST_RESPONSE_RECEIVED] = events.response_received;
        clear_mask[`ST_RESPONSE_RECEIVED] = send_pulse;
        set_mask[`ST_COMMAND_ISSUED] = events.command_issued;
        clear_mask[`ST_COMMAND_ISSUED] = send_pulse;
    end

    // ********************
    // read data mux
    // ********************
    always_comb begin
        read_word = `RESET_WORD;
        if (hit_status) begin
            read_word[`FLAGS_WIDTH-1:0] = state.flags;
        end else if (hit_control) begin
            read_word[`BIT_SEND_COMMAND] = state.control.send_command_bit;
            read_word[`BIT_START_WRITE] = state.control.start_write_bit;
            read_word[`BIT_START_READ] = state.control.start_read_bit;
        end else if (hit_mode) begin
            read_word[`BIT_EXPECT_BOOT_ACK] =
                state.mode.expect_boot_acknowledge;
            read_word[`BIT_READ_END_STOP] = state.mode.read_end_clock_stop;
        end
    end

    // ********************
    // next state
    // ********************
    always_comb begin
        next_state = state;
        if (ce) begin
            next_state.card_clock_prev = pins_sync[`PIN_CARD_CLOCK];

            // set wins over a clear in the same cycle
            next_state.flags = (state.flags & ~clear_mask) | set_mask;

            // live levels, no latching
            next_state.flags[`ST_DATA_LINE_ZERO] =
                pins_sync[`PIN_DATA_LINE_ZERO];
            next_state.flags[`ST_LOCKED] =
                pins_sync[`PIN_DLL_LOCK];
            next_state.flags[`ST_LOCK_LOST] =
                !pins_sync[`PIN_DLL_LOCK];
            next_state.flags[`ST_DATA_LINE_THREE] =
                pins_sync[`PIN_DATA_LINE_THREE];
            next_state.flags[`ST_CARD_INSERT] =
                pins_sync[`PIN_CARD_INSERT];

            // interrupt is an active low card line, sampled on card clock
            if (card_clock_rise) begin
                next_state.flags[`ST_CARD_INTERRUPT] =
                    !pins_sync[`PIN_INTERRUPT_LINE];
            end

            // hardware clears of the control bits
            if (events.response_received || events.response_timeout ||
                (events.command_issued && !levels.response_expected)) begin
                next_state.control.send_command_bit = 1'b0;
            end
            if (events.read_blocks_done || events.read_timeout ||
                set_mask[`ST_READ_END_ERROR]) begin
                // after a read-end error firmware must relaunch the read
                next_state.control.start_read_bit = 1'b0;
            end
            if (events.write_blocks_done) begin
                next_state.control.start_write_bit = 1'b0;
            end

            // firmware sets win over the hardware clears
            if (send_pulse) begin
                next_state.control.send_command_bit = 1'b1;
            end
            if (read_pulse) begin
                next_state.control.start_read_bit = 1'b1;
            end
            if (write_pulse) begin
                next_state.control.start_write_bit = 1'b1;
            end

            if (write_access && hit_mode) begin
                next_state.mode.expect_boot_acknowledge =
                    pwdata[`BIT_EXPECT_BOOT_ACK];
                next_state.mode.read_end_clock_stop =
                    pwdata[`BIT_READ_END_STOP];
            end
            // writes to the status word are dropped without error

            // read data and error are captured in the setup cycle
            if (setup) begin
                next_state.read_data = pwrite ? `RESET_WORD : read_word;
                next_state.slave_error = !mapped;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state.control <= '0;
            state.mode <= '0;
            state.flags <= `RESET_FLAGS;
            state.card_clock_prev <= 1'b0;
            state.read_data <= `RESET_WORD;
            state.slave_error <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // ********************
    // outputs
    // ********************
    // no wait states; a frozen clock enable stalls the bus instead
    always_comb begin
        pready = ce;
        pslverr = access && ce && state.slave_error;
        prdata = state.read_data;
        control = state.control;
        mode = state.mode;
        card_port_status = {13'h0000, state.flags};
    end

endmodule
`default_nettype wire

// file: design/card_port_defines.svh
// register offsets, field positions and reset values of the card port
`ifndef CARD_PORT_DEFINES_SVH
`define CARD_PORT_DEFINES_SVH

// ********************
// register offsets
// ********************
`define ADDR_STATUS 12'h000
`define ADDR_CONTROL 12'h004
`define ADDR_MODE_CONFIG 12'h008

// ********************
// control and mode fields
// ********************
`define BIT_SEND_COMMAND 0
`define BIT_START_WRITE 1
`define BIT_START_READ 2
`define BIT_EXPECT_BOOT_ACK 0
`define BIT_READ_END_STOP 1

// ********************
// status fields
// ********************
`define FLAGS_WIDTH 19
`define ST_COMMAND_ISSUED 0
`define ST_RESPONSE_RECEIVED 1
`define ST_RESPONSE_TIMEOUT 2
`define ST_RESPONSE_CRC_ERROR 3
`define ST_WRITE_DONE 4
`define ST_READ_DONE 5
`define ST_READ_TIMEOUT 6
`define ST_DATA_CRC_ERROR 7
`define ST_CARD_INTERRUPT 8
`define ST_CARD_INSERT 9
`define ST_DATA_LINE_THREE 10
`define ST_FIFO_OVERFLOW 11
`define ST_FIFO_UNDERFLOW 12
`define ST_COMMAND_COMPLETE 13
`define ST_BOOT_ACK 14
`define ST_LOCK_LOST 15
`define ST_LOCKED 16
`define ST_DATA_LINE_ZERO 17
`define ST_READ_END_ERROR 18

// ********************
// pin synchroniser lanes
// ********************
`define SYNC_WIDTH 6
`define PIN_CARD_CLOCK 0
`define PIN_DATA_LINE_ZERO 1
`define PIN_DATA_LINE_THREE 2
`define PIN_CARD_INSERT 3
`define PIN_INTERRUPT_LINE 4
`define PIN_DLL_LOCK 5

// ********************
// reset values
// ********************
`define RESET_FLAGS 19'h0_8000
`define RESET_WORD 32'h0000_0000
`define RESET_PINS 6'h00

`endif

// file: design/card_port_pkg.sv
// types shared by the card port status block
package card_port_pkg;

    // one-cycle event pulses from the command and data engines
    typedef struct packed {
        logic command_issued;
        logic response_received;
        logic response_crc_error;
        logic response_timeout;
        logic command_complete;
        logic boot_ack;
        logic write_underflow;
        logic read_overflow;
        logic data_crc_error;
        logic read_timeout;
        logic read_blocks_done;
        logic write_blocks_done;
        logic last_read_byte;
    } engine_events_t;

    // levels from the engines
    typedef struct packed {
        logic counting_busy;
        logic response_expected;
    } engine_levels_t;

    // asynchronous card side pins
    typedef struct packed {
        logic dll_lock;
        logic card_interrupt_line_n;
        logic card_insert_input;
        logic data_line_three_level;
        logic data_line_zero_level;
        logic card_clock;
    } pins_t;

    typedef struct packed {
        logic start_read_bit;
        logic start_write_bit;
        logic send_command_bit;
    } control_t;

    typedef struct packed {
        logic read_end_clock_stop;
        logic expect_boot_acknowledge;
    } mode_t;

    typedef struct packed {
        control_t control;
        mode_t mode;
        logic [18:0] flags;
        logic card_clock_prev;
        logic [31:0] read_data;
        logic slave_error;
    } status_state_t;

endpackage

// file: design/pin_sync.sv
// two flip-flop synchroniser for a group of pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] second;
        logic [WIDTH-1:0] first;
    } sync_state_t;

    sync_state_t state;
    sync_state_t next_state;

    // first stage feeds only the second stage
    always_comb begin
        next_state = state;
        if (ce) begin
            next_state.first = async_in;
            next_state.second = state.first;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign sync_out = state.second;
endmodule
`default_nettype wire

// file: tb/card_port_status_checker.sv
// concurrent checks on the card port status flags ports
`timescale 1ns/1ps
`default_nettype none
module card_port_status_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire card_port_pkg::pins_t pins,
    input wire card_port_pkg::engine_events_t events,
    input wire card_port_pkg::engine_levels_t levels,
    input wire card_port_pkg::control_t control,
    input wire card_port_pkg::mode_t mode,
    input wire logic [31:0] card_port_status
);
    // ********************
    // helpers
    // ********************
    logic ctl_wr;
    assign ctl_wr = psel && penable && pwrite && ce && paddr == 12'h004;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ********************
    // properties
    // ********************
    property p_read_end_set;
        events.last_read_byte && mode.read_end_clock_stop
            && levels.counting_busy |=> card_port_status[18];
    endproperty
    a_read_end_set: assert property (p_read_end_set)
        else $error("read-end error flag not set");
    property p_read_end_clear;
        ctl_wr && pwdata[2] && !events.last_read_byte |=> !card_port_status[18];
    endproperty
    a_read_end_clear: assert property (p_read_end_clear)
        else $error("read-end error flag not cleared");
    // four stable samples cover two sync flops and the flag register
    property p_line_zero;
        $stable(pins.data_line_zero_level) [*4]
            |-> card_port_status[17] == pins.data_line_zero_level;
    endproperty
    a_line_zero: assert property (p_line_zero)
        else $error("data line zero level not mirrored");
    property p_insert;
        $stable(pins.card_insert_input) [*4]
            |-> card_port_status[9] == pins.card_insert_input;
    endproperty
    a_insert: assert property (p_insert)
        else $error("card insert level not mirrored");
    property p_lock_pair;
        card_port_status[15] != card_port_status[16];
    endproperty
    a_lock_pair: assert property (p_lock_pair)
        else $error("lock lost is not inverse of locked");
    property p_complete_clear;
        ctl_wr && pwdata[0] && !events.command_complete
            |=> !card_port_status[13];
    endproperty
    a_complete_clear: assert property (p_complete_clear)
        else $error("completion flag not cleared by send");
    property p_overflow_set;
        events.read_overflow |=> card_port_status[11];
    endproperty
    a_overflow_set: assert property (p_overflow_set)
        else $error("overflow flag not set");
    property p_read_done;
        events.read_blocks_done |=> card_port_status[5];
    endproperty
    a_read_done: assert property (p_read_done)
        else $error("read done flag not set");
    property p_resp_timeout;
        events.response_timeout |=> card_port_status[2];
    endproperty
    a_resp_timeout: assert property (p_resp_timeout)
        else $error("response timeout flag not set");
    property p_cmd_issued;
        events.command_issued |=> card_port_status[0];
    endproperty
    a_cmd_issued: assert property (p_cmd_issued)
        else $error("command issued flag not set");
    property p_send_clear;
        control.send_command_bit && events.response_received
            && !(ctl_wr && pwdata[0]) |=> !control.send_command_bit;
    endproperty
    a_send_clear: assert property (p_send_clear)
        else $error("send bit not cleared after response");
endmodule
`default_nettype wire

// file: tb/card_model.sv
// behavioural card: pin levels and a framed card clock
`timescale 1ns/1ps
`default_nettype none
module card_model (
    output logic card_clock,
    output logic data_line_zero_level,
    output logic data_line_three_level,
    output logic card_insert_input,
    output logic card_interrupt_line_n
);
    initial begin
        card_clock = 1'b0;
        data_line_zero_level = 1'b0;
        data_line_three_level = 1'b0;
        card_insert_input = 1'b0;
        card_interrupt_line_n = 1'b1;
    end
    task automatic set_lines(input logic d0, input logic d3, input logic ins);
        data_line_zero_level <= d0;
        data_line_three_level <= d3;
        card_insert_input <= ins;
    endtask
    // clock stands still low between frames; offset keeps it off pclk edges
    task automatic frame(input logic irq, input int edges);
        #17;
        card_interrupt_line_n = !irq;
        repeat (edges) begin
            #400 card_clock = 1'b1;
            #400 card_clock = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// file: tb/card_port_status_flags_test.sv
// self-checking bench of the card port status flags
`timescale 1ns/1ps
`default_nettype none
module card_port_status_flags_test;
    logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, card_port_status, rd;
    logic pready, pslverr, er, lock = 0, cclk, d0, d3, ins, irq_n;
    logic [3:0] pv;
    card_port_pkg::pins_t pins;
    card_port_pkg::engine_events_t events = '0;
    card_port_pkg::engine_levels_t levels = '0;
    card_port_pkg::control_t control;
    card_port_pkg::mode_t mode;
    int err_count = 0, n_checks = 0;
    // event lane, status bit, clearing control bits, other control bits
    int ev_idx [13] = '{12, 11, 10, 9, 8, 6, 5, 4, 4, 3, 2, 1, 0};
    int st_bit [13] = '{0, 1, 3, 2, 13, 12, 11, 7, 7, 6, 5, 4, 18};
    int clr [13] = '{1, 1, 1, 1, 1, 2, 4, 4, 2, 4, 4, 2, 4};
    int oth [13] = '{6, 6, 6, 6, 6, 5, 3, 1, 1, 3, 3, 5, 3};
    assign pins = {lock, irq_n, ins, d3, d0, cclk};
    always #50 pclk = ~pclk;
    card_model card (.card_clock(cclk), .data_line_zero_level(d0),
        .data_line_three_level(d3), .card_insert_input(ins),
        .card_interrupt_line_n(irq_n));
    card_port_status_flags dut (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pins(pins), .events(events), .levels(levels),
        .control(control), .mode(mode), .card_port_status(card_port_status));
    // ********************
    // tasks
    // ********************
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic expect_status(input string what, input logic [31:0] exp);
        apb(1'b0, 12'h000, 32'h0000_0000, rd, er);
        check(what, rd, exp);
    endtask
    task automatic pulse(input int idx);
        @(posedge pclk);
        events <= card_port_pkg::engine_events_t'(13'h1 << idx);
        @(posedge pclk);
        events <= '0;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ********************
    // tests
    // ********************
    initial begin
        #1_000_000;
        err_count++;
        tally_and_finish();
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        expect_status("reset", 32'h0000_8000);
        $display("test reset done");
        // one pin high at a time so a swapped lane shows
        for (int k = 0; k < 5; k++) begin
            pv = 4'b0001 << k;
            lock <= pv[3];
            card.set_lines(pv[0], pv[1], pv[2]);
            repeat (5) @(posedge pclk);
            expect_status("pins", {14'h0, pv[0], pv[3], ~pv[3], 4'h0, pv[1],
                pv[2], 9'h0});
        end
        $display("test pins done");
        for (int k = 1; k >= 0; k--) begin
            card.frame(k[0], 2);
            repeat (5) @(posedge pclk);
            expect_status("card interrupt", 32'h0000_8000 | (k << 8));
        end
        $display("test interrupt done");
        apb(1'b1, 12'h008, 32'h0000_0002, rd, er);
        levels <= 2'b10;
        for (int i = 0; i < 13; i++) begin
            pulse(ev_idx[i]);
            expect_status("event set", 32'h0000_8000 | (32'h1 << st_bit[i]));
            apb(1'b1, 12'h000, 32'hFFFF_FFFF, rd, er);
            apb(1'b1, 12'h004, oth[i], rd, er);
            expect_status("kept", 32'h0000_8000 | (32'h1 << st_bit[i]));
            apb(1'b1, 12'h004, clr[i], rd, er);
            expect_status("event clear", 32'h0000_8000);
        end
        levels <= 2'b00;
        pulse(0);
        expect_status("no read-end when idle", 32'h0000_8000);
        $display("test events done");
        apb(1'b1, 12'h008, 32'h0000_0001, rd, er);
        pulse(7);
        expect_status("boot ack set", 32'h0000_C000);
        apb(1'b1, 12'h008, 32'h0000_0000, rd, er);
        expect_status("boot ack clear", 32'h0000_8000);
        $display("test boot done");
        levels <= 2'b01;
        apb(1'b1, 12'h004, 32'h0000_0001, rd, er);
        pulse(12);
        repeat (2) @(posedge pclk);
        check("send held", {31'h0, control.send_command_bit}, 32'h1);
        pulse(11);
        repeat (2) @(posedge pclk);
        check("send cleared", {31'h0, control.send_command_bit}, 32'h0);
        $display("test send done");
        apb(1'b0, 12'h00C, 32'h0000_0000, rd, er);
        check("unmapped error", {31'h0, er}, 32'h1);
        check("unmapped data", rd, 32'h0000_0000);
        $display("test unmapped done");
        tally_and_finish();
    end
endmodule
bind card_port_status_flags card_port_status_checker chk (.pclk(pclk),
    .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins), .events(events),
    .levels(levels), .control(control), .mode(mode),
    .card_port_status(card_port_status));
`default_nettype wire
